// ---- vgs_pkg.sv ----
`default_nettype none
package vgs_pkg;
  // register map, byte addresses on a 32-bit data bus
  localparam int              ADDR_W        = 8;
  localparam int              DATA_W        = 32;
  localparam int              GAIN_W        = 9;
  localparam int              PIX_W         = 8;
  localparam int              SUM_W         = 10;
  localparam logic [7:0]      OFS_LUMA_LO   = 8'h30;
  localparam logic [7:0]      OFS_U_LO      = 8'h34;
  localparam logic [7:0]      OFS_V_LO      = 8'h38;
  localparam logic [7:0]      OFS_TOP_BITS  = 8'h3C;
  localparam logic [7:0]      OFS_BRIGHT    = 8'h40;
  localparam logic [7:0]      OFS_HORIZONTAL_START_DELAY    = 8'h44;
  localparam logic [7:0]      OFS_HORIZONTAL_SCALE_FACTOR    = 8'h48;
  localparam logic [7:0]      OFS_CTRL      = 8'h4C;
  localparam logic [7:0]      OFS_STATUS    = 8'h50;
  // values after reset
  localparam logic [7:0]      RST_LUMA_LO   = 8'hD8;
  localparam logic [7:0]      RST_U_LO      = 8'hFE;
  localparam logic [7:0]      RST_V_LO      = 8'hB4;
  localparam logic [2:0]      RST_TOP_BITS  = 3'h0;
  localparam logic [7:0]      RST_BRIGHT    = 8'h00;
  localparam logic [7:0]      RST_HORIZONTAL_START_DELAY    = 8'h80;
  localparam logic [15:0]     RST_HORIZONTAL_SCALE_FACTOR    = 16'h0000;
  // field positions
  localparam int              TOP_LUMA_BIT  = 0;
  localparam int              TOP_U_BIT     = 1;
  localparam int              TOP_V_BIT     = 2;
  localparam int              CTRL_BYPASS   = 0;
  localparam int              STAT_BUF_BIT  = 16;
  // gain code 0x080 is unity, so products drop seven bits
  localparam int              GAIN_SHIFT    = 7;
  localparam logic [8:0]      GAIN_UNITY    = 9'h080;
  localparam int              BUF_DEPTH     = 2;
endpackage : vgs_pkg
`default_nettype wire

// ---- vgs_gain_unit.sv ----
`timescale 1ns/1ns
`default_nettype none
module vgs_gain_unit #(
  parameter bit IS_CHROMA = 1'b0
) (
  input  wire logic signed [vgs_pkg::SUM_W-1:0]  sample_in,
  input  wire logic        [vgs_pkg::GAIN_W-1:0] gain,
  output logic             [vgs_pkg::PIX_W-1:0]  sample_out
);
  import vgs_pkg::*;

  logic signed [19:0] product;
  logic signed [19:0] scaled;

  // multiply, divide by 128, then clamp to the component range
  always_comb begin
    product = sample_in * $signed({1'b0, gain});
    scaled  = product >>> GAIN_SHIFT;
    if (IS_CHROMA) begin
      if (scaled > 20'sd127) begin
        sample_out = 8'h7F;
      end else if (scaled < -20'sd128) begin
        sample_out = 8'h80;
      end else begin
        sample_out = scaled[7:0];
      end
    end else begin
      if (scaled > 20'sd255) begin
        sample_out = 8'hFF;
      end else if (scaled < 20'sd0) begin
        sample_out = 8'h00;
      end else begin
        sample_out = scaled[7:0];
      end
    end
  end
endmodule : vgs_gain_unit
`default_nettype wire

// ---- vgs_pix_buffer.sv ----
`timescale 1ns/1ns
`default_nettype none
module vgs_pix_buffer #(
  parameter int WIDTH = 24,
  parameter int DEPTH = vgs_pkg::BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import vgs_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // honest flags: ready only while an entry is free
  assign in_ready  = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer arithmetic with wrap for any depth
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    if (push) begin
      wr_next = (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    end
    cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage needs no reset, valid is tracked by the count
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule : vgs_pix_buffer
`default_nettype wire

// ---- vgs_gain_top.sv ----
// Function
// - reset loads luma gain low byte D8
// - top bit above low byte forms 9-bit gain
// - luma times gain, 080 means unity
// - brightness added before luma gain multiply
// - reset loads V gain low byte B4
// - V times 9-bit gain, zero blanks
// - reset loads U gain low byte FE
// - U times 9-bit gain, 080 unity
// - bypass setting skips chroma filters
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module vgs_gain_top (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic [vgs_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [vgs_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [vgs_pkg::DATA_W-1:0]   avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [vgs_pkg::PIX_W-1:0]    in_y,
  input  wire logic [vgs_pkg::PIX_W-1:0]    in_u,
  input  wire logic [vgs_pkg::PIX_W-1:0]    in_v,
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic      [vgs_pkg::PIX_W-1:0]    out_y,
  output logic      [vgs_pkg::PIX_W-1:0]    out_u,
  output logic      [vgs_pkg::PIX_W-1:0]    out_v,
  output logic      [7:0]                   horizontal_start_delay,
  output logic      [15:0]                  horizontal_scale_factor
);
  import vgs_pkg::*;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } vgs_bus_t;

  vgs_bus_t    bus_reg, bus_next;
  logic [7:0]  luma_gain_low_byte, luma_lo_next;
  logic [7:0]  u_chroma_gain_low_byte, u_lo_next;
  logic [7:0]  v_chroma_gain_low_byte, v_lo_next;
  logic [2:0]  top_reg, top_next;
  logic [7:0]  bright_reg, bright_next;
  logic [7:0]  horizontal_start_delay_reg, horizontal_start_delay_next;
  logic [15:0] horizontal_scale_factor_reg, horizontal_scale_factor_next;
  logic        bypass_reg, bypass_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] pix_cnt_reg, pix_cnt_next;
  logic        do_write;

  logic [8:0]  luma_gain, u_gain, v_gain;
  logic        chroma_filter_bypass;
  logic        accept;
  logic [7:0]  prev_u_reg, prev_u_next, prev_v_reg, prev_v_next;
  logic [7:0]  filt_u, filt_v;
  logic signed [9:0] luma_sum, u_ext, v_ext;
  logic [7:0]  gy, gu, gv;
  logic        stage_valid_reg, stage_valid_next;
  logic [23:0] stage_reg, stage_next;
  logic        buf_in_ready;
  logic [23:0] buf_out;

  // two-tap chroma average; halves the chroma bandwidth ahead of scaling
  function automatic logic [7:0] vgs_avg(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    return s[8:1];
  endfunction : vgs_avg

  // register read mux, reserved bits read as zero
  function automatic logic [31:0] vgs_rd_mux(input logic [7:0] adr);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (adr)
      OFS_LUMA_LO:  d[7:0]  = luma_gain_low_byte;
      OFS_U_LO:     d[7:0]  = u_chroma_gain_low_byte;
      OFS_V_LO:     d[7:0]  = v_chroma_gain_low_byte;
      OFS_TOP_BITS: d[2:0]  = top_reg;
      OFS_BRIGHT:   d[7:0]  = bright_reg;
      OFS_HORIZONTAL_START_DELAY:   d[7:0]  = horizontal_start_delay_reg;
      OFS_HORIZONTAL_SCALE_FACTOR:   d[15:0] = horizontal_scale_factor_reg;
      OFS_CTRL:     d[0]    = bypass_reg;
      OFS_STATUS: begin
        d[15:0]          = pix_cnt_reg;
        d[STAT_BUF_BIT]  = out_valid;
      end
      default:      d = 32'h0000_0000;
    endcase
    return d;
  endfunction : vgs_rd_mux

  // every access waits exactly one cycle; unmapped ones complete too
  assign avs_waitrequest = (avs_read | avs_write) & (bus_reg != BUS_ACK);
  assign avs_readdata    = rdata_reg;
  assign do_write        = avs_write & (bus_reg == BUS_ACK);

  // bus sequencing and register writes
  always_comb begin
    bus_next     = bus_reg;
    luma_lo_next = luma_gain_low_byte;
    u_lo_next    = u_chroma_gain_low_byte;
    v_lo_next    = v_chroma_gain_low_byte;
    top_next     = top_reg;
    bright_next  = bright_reg;
    horizontal_start_delay_next  = horizontal_start_delay_reg;
    horizontal_scale_factor_next  = horizontal_scale_factor_reg;
    bypass_next  = bypass_reg;
    rdata_next   = rdata_reg;
    unique case (bus_reg)
      BUS_IDLE: begin
        if (avs_read | avs_write) begin
          bus_next = BUS_ACK;
        end
        // read data captured early so it stands during the answer cycle
        if (avs_read) begin
          rdata_next = vgs_rd_mux(avs_address);
        end
      end
      BUS_ACK: begin
        bus_next = BUS_IDLE;
      end
    endcase
    if (do_write && avs_byteenable[0]) begin
      unique case (avs_address)
        OFS_LUMA_LO:  luma_lo_next = avs_writedata[7:0];
        OFS_U_LO:     u_lo_next    = avs_writedata[7:0];
        OFS_V_LO:     v_lo_next    = avs_writedata[7:0];
        OFS_TOP_BITS: top_next     = avs_writedata[2:0];
        OFS_BRIGHT:   bright_next  = avs_writedata[7:0];
        OFS_HORIZONTAL_START_DELAY:   horizontal_start_delay_next  = avs_writedata[7:0];
        OFS_HORIZONTAL_SCALE_FACTOR:   horizontal_scale_factor_next[7:0] = avs_writedata[7:0];
        OFS_CTRL:     bypass_next  = avs_writedata[CTRL_BYPASS];
        default:      bypass_next  = bypass_reg;
      endcase
    end
    if (do_write && avs_byteenable[1] && (avs_address == OFS_HORIZONTAL_SCALE_FACTOR)) begin
      horizontal_scale_factor_next[15:8] = avs_writedata[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_reg                <= BUS_IDLE;
      luma_gain_low_byte     <= RST_LUMA_LO;
      u_chroma_gain_low_byte <= RST_U_LO;
      v_chroma_gain_low_byte <= RST_V_LO;
      top_reg                <= RST_TOP_BITS;
      bright_reg             <= RST_BRIGHT;
      horizontal_start_delay_reg             <= RST_HORIZONTAL_START_DELAY;
      horizontal_scale_factor_reg             <= RST_HORIZONTAL_SCALE_FACTOR;
      bypass_reg             <= 1'b0;
      rdata_reg              <= 32'h0000_0000;
    end else begin
      bus_reg                <= bus_next;
      luma_gain_low_byte     <= luma_lo_next;
      u_chroma_gain_low_byte <= u_lo_next;
      v_chroma_gain_low_byte <= v_lo_next;
      top_reg                <= top_next;
      bright_reg             <= bright_next;
      horizontal_start_delay_reg             <= horizontal_start_delay_next;
      horizontal_scale_factor_reg             <= horizontal_scale_factor_next;
      bypass_reg             <= bypass_next;
      rdata_reg              <= rdata_next;
    end
  end

  assign horizontal_start_delay  = horizontal_start_delay_reg;
  assign horizontal_scale_factor = horizontal_scale_factor_reg;
  assign chroma_filter_bypass    = bypass_reg;

  // 9-bit gains: separate top bit above each low byte
  assign luma_gain = {top_reg[TOP_LUMA_BIT], luma_gain_low_byte};
  assign u_gain    = {top_reg[TOP_U_BIT], u_chroma_gain_low_byte};
  assign v_gain    = {top_reg[TOP_V_BIT], v_chroma_gain_low_byte};

  // input stalls only when the stage is full and the buffer refuses it
  assign in_ready = ~stage_valid_reg | buf_in_ready;
  assign accept   = in_valid & in_ready;

  // brightness enters ahead of the gain so it is scaled as well
  assign luma_sum = $signed({2'b00, in_y}) + $signed({{2{bright_reg[7]}}, bright_reg});
  assign filt_u   = chroma_filter_bypass ? in_u : vgs_avg(in_u, prev_u_reg);
  assign filt_v   = chroma_filter_bypass ? in_v : vgs_avg(in_v, prev_v_reg);
  assign u_ext    = $signed({{2{filt_u[7]}}, filt_u});
  assign v_ext    = $signed({{2{filt_v[7]}}, filt_v});

  vgs_gain_unit #(.IS_CHROMA(1'b0)) u_gain_y (
    .sample_in  (luma_sum),
    .gain       (luma_gain),
    .sample_out (gy)
  );
  vgs_gain_unit #(.IS_CHROMA(1'b1)) u_gain_u (
    .sample_in  (u_ext),
    .gain       (u_gain),
    .sample_out (gu)
  );
  vgs_gain_unit #(.IS_CHROMA(1'b1)) u_gain_v (
    .sample_in  (v_ext),
    .gain       (v_gain),
    .sample_out (gv)
  );

  // gains are sampled with the pixel at acceptance, so a register
  // write never alters a pixel already past the input
  always_comb begin
    stage_valid_next = stage_valid_reg;
    stage_next       = stage_reg;
    prev_u_next      = prev_u_reg;
    prev_v_next      = prev_v_reg;
    pix_cnt_next     = pix_cnt_reg;
    if (buf_in_ready) begin
      stage_valid_next = 1'b0;
    end
    if (accept) begin
      stage_valid_next = 1'b1;
      stage_next       = {gy, gu, gv};
      prev_u_next      = in_u;
      prev_v_next      = in_v;
      pix_cnt_next     = pix_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stage_valid_reg <= 1'b0;
      stage_reg       <= 24'h00_0000;
      prev_u_reg      <= 8'h00;
      prev_v_reg      <= 8'h00;
      pix_cnt_reg     <= 16'h0000;
    end else begin
      stage_valid_reg <= stage_valid_next;
      stage_reg       <= stage_next;
      prev_u_reg      <= prev_u_next;
      prev_v_reg      <= prev_v_next;
      pix_cnt_reg     <= pix_cnt_next;
    end
  end

  // two entries absorb a receiver stall without dropping a word
  vgs_pix_buffer #(.WIDTH(24), .DEPTH(BUF_DEPTH)) u_buf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (stage_valid_reg),
    .in_ready  (buf_in_ready),
    .in_data   (stage_reg),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (buf_out)
  );

  assign out_y = buf_out[23:16];
  assign out_u = buf_out[15:8];
  assign out_v = buf_out[7:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // register reset values observed right after reset
  chk_luma_reset_val: assert property ($fell(reset) |-> luma_gain_low_byte == 8'hD8)
    else $error("luma gain reset value wrong");
  chk_v_reset_val: assert property ($fell(reset) |-> v_chroma_gain_low_byte == 8'hB4)
    else $error("V gain reset value wrong");
  chk_u_reset_val: assert property ($fell(reset) |-> u_chroma_gain_low_byte == 8'hFE)
    else $error("U gain reset value wrong");
  chk_luma_unity_gain: assert property (accept && luma_gain == 9'h080 && bright_reg == 8'h00
    |=> stage_reg[23:16] == $past(in_y))
    else $error("unity luma gain altered sample");
  chk_top_bit_doubles: assert property (accept && luma_gain == 9'h100 && bright_reg == 8'h00
    && in_y < 8'h80 |=> stage_reg[23:16] == {$past(in_y[6:0]), 1'b0})
    else $error("top gain bit did not double luma");
  chk_bright_is_gained: assert property (accept && luma_gain == 9'h000
    |=> stage_reg[23:16] == 8'h00)
    else $error("brightness escaped zero gain");
  chk_v_zero_blank: assert property (accept && v_gain == 9'h000 |=> stage_reg[7:0] == 8'h00)
    else $error("zero V gain did not blank");
  chk_luma_clamp_top: assert property (accept && in_y == 8'hFF && !bright_reg[7]
    && luma_gain > 9'h080 |=> stage_reg[23:16] == 8'hFF)
    else $error("luma not clamped at full scale");
  chk_bypass_raw_u: assert property (accept && chroma_filter_bypass && u_gain == 9'h080
    |=> stage_reg[15:8] == $past(in_u))
    else $error("bypass did not pass raw U");
  chk_gain_write_apply: assert property (do_write && avs_address == OFS_LUMA_LO
    && avs_byteenable[0] |=> luma_gain_low_byte == $past(avs_writedata[7:0]))
    else $error("luma gain write not applied");
  chk_bus_one_wait: assert property ($rose(avs_read) && bus_reg == BUS_IDLE
    |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  cov_stall_full: cover property (out_valid && !out_ready && !buf_in_ready && stage_valid_reg);
  cov_luma_write: cover property (do_write && avs_address == OFS_LUMA_LO);
  cov_bypass_pixel: cover property (accept && chroma_filter_bypass);
  cov_back_to_back: cover property (accept ##1 accept ##1 accept);
endmodule : vgs_gain_top
`default_nettype wire

// ---- vgs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import vgs_pkg::*;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = 8'h00;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              in_valid = 1'b0;
  logic              in_ready;
  logic [PIX_W-1:0]  in_y = 8'h00;
  logic [PIX_W-1:0]  in_u = 8'h00;
  logic [PIX_W-1:0]  in_v = 8'h00;
  logic              out_valid;
  logic              out_ready = 1'b0;
  logic [PIX_W-1:0]  out_y;
  logic [PIX_W-1:0]  out_u;
  logic [PIX_W-1:0]  out_v;
  logic [7:0]        horizontal_start_delay;
  logic [15:0]       horizontal_scale_factor;
  int                n_fail = 0;
  int                total_checks = 0;

  // free-running pixel clock, 100 ns period
  always #50 clk = ~clk;

  vgs_gain_top i_vgs_gain_top (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .in_valid(in_valid), .in_ready(in_ready), .in_y(in_y), .in_u(in_u), .in_v(in_v),
    .out_valid(out_valid), .out_ready(out_ready), .out_y(out_y), .out_u(out_u),
    .out_v(out_v), .horizontal_start_delay(horizontal_start_delay),
    .horizontal_scale_factor(horizontal_scale_factor)
  );

  // one compare task for each kind of result
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pix(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t pixel got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pix

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // bus master: waitrequest is sampled at the rising edge, and the request
  // drops at the very edge that answers it; only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    chk_reg(32'(n), 32'h0000_0002); // one wait state, answered at the second edge
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    avs_read <= 1'b1;
    avs_address <= a;
    do begin @(posedge clk); end while (avs_waitrequest !== 1'b0);
    chk_reg(avs_readdata, exp);
    avs_read <= 1'b0;
  endtask : rd_chk

  // offer one pixel and hold it until the block takes it or 50 cycles pass
  task automatic push(input logic [23:0] p);
    int n;
    n = 0;
    @(posedge clk);
    in_valid <= 1'b1;
    in_y <= p[23:16];
    in_u <= p[15:8];
    in_v <= p[7:0];
    do begin @(posedge clk); n++; end while (in_ready !== 1'b1 && n < 50);
    in_valid <= 1'b0;
    if (n >= 50) chk_bit(in_ready, 1'b1);
  endtask : push

  task automatic pop(input logic [23:0] e);
    int n;
    n = 0;
    @(posedge clk);
    out_ready <= 1'b1;
    do begin @(posedge clk); n++; end while (out_valid !== 1'b1 && n < 50);
    chk_bit(out_valid, 1'b1);
    chk_pix({out_y, out_u, out_v}, e);
    out_ready <= 1'b0;
  endtask : pop

  task automatic t_reset_values();
    rd_chk(8'h30, 32'h0000_00D8);
    rd_chk(8'h34, 32'h0000_00FE);
    rd_chk(8'h38, 32'h0000_00B4);
    rd_chk(8'h3C, 32'h0);
    rd_chk(8'h44, 32'h0000_0080);
    rd_chk(8'h4C, 32'h0);
    rd_chk(8'h60, 32'h0);
    chk_reg({8'h00, horizontal_scale_factor, horizontal_start_delay}, 32'h0000_0080);
    $display("test reset_values done");
  endtask : t_reset_values

  // unity gains, chroma filters bypassed: the pixel passes unchanged
  task automatic t_unity();
    wr(8'h30, 32'h80, 4'h1);
    wr(8'h34, 32'h80, 4'h1);
    wr(8'h38, 32'h80, 4'h1);
    wr(8'h4C, 32'h1, 4'h1);
    push(24'h55_90_30);
    pop(24'h55_90_30);
    $display("test unity done");
  endtask : t_unity

  // top luma bit set gives 0x1FF; results floor and clamp
  task automatic t_gain_math();
    wr(8'h3C, 32'h1, 4'h1);
    wr(8'h30, 32'hFF, 4'h1);
    wr(8'h34, 32'hB4, 4'h1);
    wr(8'h38, 32'h00, 4'h1);
    push(24'h20_40_7F);
    pop(24'h7F_5A_00);
    push(24'h40_C0_10);
    pop(24'hFF_A6_00);
    wr(8'h38, 32'hFF, 4'h1);
    push(24'h01_00_10);
    pop(24'h03_00_1F);
    push(24'h00_7F_80);
    pop(24'h00_7F_80);
    push(24'hFF_00_00);
    pop(24'hFF_00_00);
    $display("test gain_math done");
  endtask : t_gain_math

  // brightness lands ahead of a 2x luma gain, so it is doubled too
  task automatic t_bright();
    wr(8'h30, 32'h00, 4'h1);
    wr(8'h34, 32'h80, 4'h1);
    wr(8'h38, 32'h80, 4'h1);
    push(24'h30_00_00);
    pop(24'h60_00_00);
    wr(8'h40, 32'h10, 4'h1);
    push(24'h30_00_00);
    pop(24'h80_00_00);
    wr(8'h40, 32'hF0, 4'h1);
    push(24'h30_00_00);
    pop(24'h40_00_00);
    // zero gain must swallow the brightness offset as well
    wr(8'h3C, 32'h0, 4'h1);
    push(24'h30_00_00);
    pop(24'h00_00_00);
    wr(8'h40, 32'h00, 4'h1);
    wr(8'h30, 32'h80, 4'h1);
    $display("test bright done");
  endtask : t_bright

  // filters on: each chroma output averages with the previous raw sample (zero for the first pixel here)
  task automatic t_filter();
    wr(8'h4C, 32'h0, 4'h1);
    push(24'h00_20_10);
    pop(24'h00_10_08);
    push(24'h00_40_F0);
    pop(24'h00_30_00);
    wr(8'h4C, 32'h1, 4'h1);
    $display("test filter done");
  endtask : t_filter

  // receiver stalls: three words fit, the fourth is refused, none is lost
  task automatic t_stall();
    push(24'h11_00_00);
    push(24'h22_00_00);
    push(24'h33_00_00);
    @(posedge clk);
    in_valid <= 1'b1;
    in_y <= 8'h44;
    repeat (3) @(negedge clk);
    chk_bit(in_ready, 1'b0);
    rd_chk(8'h50, 32'h0001_000F);
    @(posedge clk);
    in_valid <= 1'b0;
    // halving the gain now must not touch words already inside
    wr(8'h30, 32'h40, 4'h1);
    pop(24'h11_00_00);
    pop(24'h22_00_00);
    pop(24'h33_00_00);
    push(24'h44_00_00);
    pop(24'h22_00_00);
    @(negedge clk);
    chk_bit(out_valid, 1'b0);
    $display("test stall done");
  endtask : t_stall

  // 720 active pixels scaled to 360 wanted
  task automatic t_hregs();
    wr(8'h44, 32'h40, 4'h1);
    wr(8'h48, 32'h1000, 4'h3);
    // the write lands at the edge wr returns on, so look half a cycle later
    @(negedge clk);
    chk_reg({8'h00, horizontal_scale_factor, horizontal_start_delay}, 32'h0010_0040);
    wr(8'h48, 32'hFFFF, 4'h1);
    rd_chk(8'h48, 32'h0000_10FF);
    wr(8'h44, 32'h42, 4'h1);
    wr(8'h60, 32'h5A, 4'hF);
    rd_chk(8'h60, 32'h0);
    rd_chk(8'h44, 32'h0000_0042);
    chk_reg({8'h00, horizontal_scale_factor, horizontal_start_delay}, 32'h0010_FF42);
    // a SECAM source takes a unity chroma code of its own, not 0x80
    wr(8'h34, 32'h70, 4'h1);
    rd_chk(8'h34, 32'h0000_0070);
    $display("test hregs done");
  endtask : t_hregs

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    t_unity();
    t_gain_math();
    t_bright();
    t_filter();
    t_stall();
    t_hregs();
    tally_and_finish();
  end

  // the run needs well under a thousand cycles; a hang ends here
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("BAD t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
